// ---- e1_rx_signaling_datalink_select_test.sv ----
// testbench: select codes, data link, change flags and interrupt of ers_top
`timescale 1ns/10ps
`default_nettype none
module e1_rx_signaling_datalink_select_test;
  import ers_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        run, slow, locked, er, e_ser;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd, lf;
  logic [7:0]  pay, sig, msel, flags, e_sd, snap;
  logic [4:0]  rx_dl_bits, rx_dl_valid, e_dlv, e_dlb;
  logic [2:0]  cd;
  logic [7:0]  arr [32] = '{default: 8'h00};
  int          num_errors, checked, k;
  ers_slot_s   rx_slot;
  ers_byte_s   rx_serial_out, rx_fractional_out, rx_overhead_out, rx_signaling_out;

  ers_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_slot(rx_slot), .rx_cas_locked(locked),
    .rx_serial_out(rx_serial_out), .rx_fractional_out(rx_fractional_out),
    .rx_overhead_out(rx_overhead_out), .rx_signaling_out(rx_signaling_out),
    .rx_dl_bits(rx_dl_bits), .rx_dl_valid(rx_dl_valid), .irq(irq));
  ers_framer i_framer (.pclk(pclk), .presetn(presetn), .run(run), .slow(slow),
    .pay(pay), .sig(sig), .slot(rx_slot));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (e !== s) begin
      $display("[ERR] %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    if (n >= 50) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // clock and random payload
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    lf <= lfsr(lf);
    pay <= lf[7:0];
  end

  // reference model, compared at every edge
  always @(posedge pclk) begin
    if (!presetn) begin
      e_dlv = 5'h00;
      e_ser = 1'b0;
      msel = SEL_RESET;
      flags = CHG_RESET;
      snap = CHG_RESET;
    end else begin
      chk("dl valid", {3'h0, e_dlv}, {3'h0, rx_dl_valid});
      if (e_dlv != 5'h00) chk("dl bits", {3'h0, e_dlb}, {3'h0, rx_dl_bits});
      if (e_ser) chk("serial", e_sd, rx_serial_out.valid ? rx_serial_out.data : ~e_sd);
      if (psel && penable && pready && !pwrite && paddr == 14'h434) begin
        chk("change flags", snap, prdata[7:0]);
        flags = flags & ~snap;
      end
      // read word is latched one edge before completion
      if (psel && penable && !pready && !pwrite && paddr == 14'h434) snap = flags;
      cd = msel[2:0];
      e_dlv = 5'h00;
      e_ser = rx_slot.valid && (rx_slot.num == TS_SIG || cd > 3'h4);
      e_sd = rx_slot.data;
      if (rx_slot.valid && rx_slot.num == TS_FRAME && !rx_slot.fas) begin
        if (cd inside {3'h0, 3'h1, 3'h4}) e_dlv = msel[7:3];
        if (cd inside {3'h2, 3'h3}) e_dlv = NAT_ONES;
        e_dlb = (cd inside {3'h2, 3'h3}) ? NAT_ONES : rx_slot.data[7:3] & msel[7:3];
      end
      if (rx_slot.valid && rx_slot.num == TS_SIG) begin
        k = rx_slot.mf;
        if ((cd == 3'h1 || cd == 3'h3) && k != 0) begin
          if (locked && k < 8 && arr[k][3:0] != rx_slot.data[7:4]) flags[7-k] = 1'b1;
          arr[k] = {4'h0, rx_slot.data[7:4]};
          arr[k+16] = {4'h0, rx_slot.data[3:0]};
        end else if (cd == 3'h2)
          arr[k] = rx_slot.data;
      end
      if (psel && penable && pready && pwrite && paddr == 14'h430) msel = pwdata[7:0];
    end
  end

  // watchdog
  initial begin
    #200000;
    num_errors++;
    summarize();
  end

  initial begin
    {psel, penable, pwrite, run, slow, locked, presetn} = 7'h00;
    paddr = 14'h0000;
    pwdata = 32'h0;
    sig = 8'h00;
    lf = 32'h1482;
    pay = 8'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 14'h430, 32'h0);
    chk("select reset", SEL_RESET, rd[7:0]);
    apb(1'b0, 14'h0FFC, 32'h0);
    chk("unmapped error", 8'h01, {7'h00, er});
    apb(1'b1, 14'h440, 32'h0F);
    run <= 1'b1;
    // every select code, prompt stream for even codes, slow stream for odd codes
    for (int c = 0; c < 8; c++) begin
      slow <= c[0];
      apb(1'b1, 14'h430, {24'h0, lf[7:3], c[2:0]});
      repeat (140) @(posedge pclk);
      apb(1'b0, 14'h430, 32'h0);
      chk("select readback", msel, rd[7:0]);
    end
    // cas: refresh unlocked, then change locked, then change unlocked
    slow <= 1'b0;
    sig <= 8'h5A;
    apb(1'b1, 14'h430, 32'h01);
    repeat (520) @(posedge pclk);
    locked <= 1'b1;
    apb(1'b0, 14'h434, 32'h0);
    sig <= 8'hC3;
    repeat (520) @(posedge pclk);
    apb(1'b0, 14'h434, 32'h0);
    apb(1'b0, 14'h434, 32'h0);
    locked <= 1'b0;
    sig <= 8'h3C;
    repeat (520) @(posedge pclk);
    apb(1'b0, 14'h434, 32'h0);
    run <= 1'b0;
    repeat (4) @(posedge pclk);
    for (int j = 1; j < 8; j++) begin
      apb(1'b0, 14'h1400 + 14'(4 * j), 32'h0);
      chk("signaling array", arr[j], rd[7:0]);
    end
    // interrupt raised, masked, cleared
    apb(1'b1, 14'h448, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq raised", 8'h01, {7'h00, irq});
    apb(1'b1, 14'h448, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 8'h00, {7'h00, irq});
    apb(1'b1, 14'h448, 32'h1);
    apb(1'b1, 14'h444, 32'h3);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 8'h00, {7'h00, irq});
    summarize();
  end
endmodule
`default_nettype wire

// ---- ers_framer.sv ----
// partner: receive framer model producing the timeslot stream
`timescale 1ns/10ps
`default_nettype none
module ers_framer (
  // clock and reset
  input wire logic          pclk,
  input wire logic          presetn,
  // control
  input wire logic          run,
  input wire logic          slow,
  input wire logic [7:0]    pay,
  input wire logic [7:0]    sig,
  // stream
  output var ers_pkg::ers_slot_s slot
);
  import ers_pkg::*;
  logic [4:0] ts;
  logic [3:0] mf;
  logic       odd;
  logic       gap;
  // slot counter, frame parity and multiframe number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts <= 5'h00;
      mf <= 4'h0;
      odd <= 1'b0;
      gap <= 1'b0;
      slot <= '0;
    end else begin
      gap <= slow & ~gap;
      slot.valid <= run & ~gap;
      if (run & ~gap) begin
        slot.num <= ts;
        slot.mf <= mf;
        slot.fas <= ~odd;
        slot.de <= 1'b0;
        slot.data <= (ts == TS_SIG) ? sig : pay;
        ts <= ts + 5'h01;
        if (ts == 5'h1F) begin
          odd <= ~odd;
          mf <= mf + 4'h1;
        end
      end else
        slot.data <= ~slot.data; // idle data not held
    end
  end
endmodule
`default_nettype wire

// ---- ers_pkg.sv ----
// package: constants, register map and carrier types of the e1 receive signaling select block
// Function
// - nat8 enable takes non-FAS bit 7
// - nat7 enable takes non-FAS bit 6
// - nat6 enable takes non-FAS bit 5
// - nat5 enable takes non-FAS bit 4
// - nat4 enable takes non-FAS bit 3
// - national enables honoured only for codes 000/001/100
// - those codes treat national bits as data link
// - select field routes D/E, national, timeslot 16
// - codes 001/011 enable CAS, route timeslot 16
// - code 010 forces ones, timeslot 16 only
// - CAS codes put timeslot 16 on overhead
// - CAS timeslot 16 selectable, serial among them
// - change flags ts0..7, bit 7 is ts0
// - flag sets on CAS change while CAS locked, read clears
// - timeslot 0 flag never sets
// - flags update only with CAS stream
`default_nettype none
package ers_pkg;
  // register indices, byte address is index times four
  localparam logic [11:0] IDX_SEL      = 12'h10C;
  localparam logic [11:0] IDX_CHG      = 12'h10D;
  localparam logic [11:0] IDX_ROUTE    = 12'h110;
  localparam logic [11:0] IDX_STAT     = 12'h111;
  localparam logic [11:0] IDX_MASK     = 12'h112;
  localparam logic [11:0] IDX_ARR_BASE = 12'h500;
  localparam logic [11:0] IDX_ARR_LAST = 12'h51F;
  localparam int          ARR_DEPTH    = 32;
  localparam int          CHG_SLOTS    = 8;
  // reset values
  localparam logic [7:0]  SEL_RESET    = 8'h00;
  localparam logic [7:0]  CHG_RESET    = 8'h00;
  localparam logic [7:0]  ROUTE_RESET  = 8'h0C;
  localparam logic [1:0]  STAT_RESET   = 2'h0;
  localparam logic [1:0]  MASK_RESET   = 2'h0;
  // select codes
  localparam logic [2:0]  SEL_DL_PLAIN = 3'h0;
  localparam logic [2:0]  SEL_DL_CAS   = 3'h1;
  localparam logic [2:0]  SEL_ONES     = 3'h2;
  localparam logic [2:0]  SEL_ONES_CAS = 3'h3;
  localparam logic [2:0]  SEL_DL_SIG   = 3'h4;
  // timeslots and multiframe positions
  localparam logic [4:0]  TS_FRAME     = 5'h00;
  localparam logic [4:0]  TS_SIG       = 5'h10;
  localparam logic [3:0]  MF_ALIGN     = 4'h0;
  localparam logic [3:0]  MF_LAST_CHG  = 4'h7;
  localparam logic [4:0]  NAT_ONES     = 5'h1F;
  // status bit positions
  localparam int          STAT_CHG     = 0;
  localparam int          STAT_DL      = 1;
  localparam int          STAT_W       = 2;

  // select register layout: enables for nat8..nat4 then code
  typedef struct packed {
    logic [4:0] nat_en;
    logic [2:0] code;
  } ers_sel_s;

  // destination register layout
  typedef struct packed {
    logic [2:0] unused;
    logic       de_to_serial;
    logic       ts16_serial;
    logic       ts16_array;
    logic       ts16_overhead;
    logic       ts16_signaling;
  } ers_route_s;

  // one received timeslot from the framer
  typedef struct packed {
    logic       valid;
    logic       fas;
    logic       de;
    logic [3:0] mf;
    logic [4:0] num;
    logic [7:0] data;
  } ers_slot_s;

  // one byte handed to a pin
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ers_byte_s;
endpackage
`default_nettype wire

// ---- ers_properties.sv ----
// checker: select, data link and change flag properties of ers_top
`timescale 1ns/10ps
`default_nettype none
module ers_properties (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [13:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  // stream and pins
  input wire ers_pkg::ers_slot_s rx_slot,
  input wire ers_pkg::ers_byte_s rx_serial_out,
  input wire ers_pkg::ers_byte_s rx_fractional_out,
  input wire ers_pkg::ers_byte_s rx_overhead_out,
  input wire ers_pkg::ers_byte_s rx_signaling_out,
  input wire logic [4:0]         rx_dl_bits,
  input wire logic [4:0]         rx_dl_valid
);
  import ers_pkg::*;
  logic [7:0] sel;
  // mirror of the select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sel <= SEL_RESET;
    else if (psel && penable && pready && pwrite && paddr == 14'h430)
      sel <= pwdata[7:0];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ts0(logic c);
    rx_slot.valid && rx_slot.num == TS_FRAME && !rx_slot.fas && c;
  endsequence
  sequence s_ts16(logic c);
    rx_slot.valid && rx_slot.num == TS_SIG && c;
  endsequence
  sequence s_read(logic [13:0] a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  a_nat_taken: assert property (
    s_ts0(sel[2:0] inside {3'h0, 3'h1, 3'h4}) |=> rx_dl_valid == $past(sel[7:3])
    && rx_dl_bits == ($past(rx_slot.data[7:3]) & $past(sel[7:3])))
    else $error("national bits not taken as enabled");
  a_nat_ones: assert property (
    s_ts0(sel[2:0] inside {3'h2, 3'h3}) |=> rx_dl_valid == NAT_ONES && rx_dl_bits == NAT_ONES)
    else $error("data link not forced to ones");
  a_unused_quiet: assert property (
    rx_slot.valid && sel[2:0] > 3'h4 |=> rx_dl_valid == 5'h00 && !rx_overhead_out.valid
    && !rx_signaling_out.valid && !rx_fractional_out.valid)
    else $error("unused code extracted something");
  a_unused_serial: assert property (
    rx_slot.valid && sel[2:0] > 3'h4 |=> rx_serial_out.valid
    && rx_serial_out.data == $past(rx_slot.data))
    else $error("unused code lost serial byte");
  a_ts16_serial: assert property (
    s_ts16(sel[2:0] inside {3'h0, 3'h4}) |=> rx_serial_out.valid
    && rx_serial_out.data == $past(rx_slot.data))
    else $error("timeslot 16 missing on serial");
  a_ovh_ts16: assert property (
    rx_overhead_out.valid |-> $past(rx_slot.valid) && $past(rx_slot.num) == TS_SIG)
    else $error("overhead pin outside timeslot 16");
  a_sig_ts16: assert property (
    rx_signaling_out.valid && $past(sel[2:0]) == SEL_ONES |-> $past(rx_slot.num) == TS_SIG)
    else $error("signaling pin outside timeslot 16");
  a_chg_ts0: assert property (
    s_read(14'h434) |-> !prdata[7])
    else $error("timeslot 0 change flag set");
  a_sel_read: assert property (
    s_read(14'h430) |-> prdata[7:0] == sel)
    else $error("select readback wrong");
endmodule
bind ers_top ers_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .rx_slot(rx_slot), .rx_serial_out(rx_serial_out),
  .rx_fractional_out(rx_fractional_out), .rx_overhead_out(rx_overhead_out),
  .rx_signaling_out(rx_signaling_out), .rx_dl_bits(rx_dl_bits), .rx_dl_valid(rx_dl_valid));
`default_nettype wire

// ---- ers_top.sv ----
// module: e1 receive signaling and data link select with change flags
`timescale 1ns/10ps
`default_nettype none
module ers_top (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [13:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output var  logic [31:0]      prdata,
  output var  logic             pready,
  output var  logic             pslverr,
  // receive framer stream
  input  wire ers_pkg::ers_slot_s rx_slot,
  input  wire logic             rx_cas_locked,
  // terminal equipment pins
  output var  ers_pkg::ers_byte_s rx_serial_out,
  output var  ers_pkg::ers_byte_s rx_fractional_out,
  output var  ers_pkg::ers_byte_s rx_overhead_out,
  output var  ers_pkg::ers_byte_s rx_signaling_out,
  output var  logic [4:0]       rx_dl_bits,
  output var  logic [4:0]       rx_dl_valid,
  // interrupt
  output var  logic             irq
);
  import ers_pkg::*;

  // register state
  ers_sel_s        rx_sig_link_select_reg;
  ers_route_s      route;
  logic [7:0]      rx_sig_change_reg0;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] mask;
  logic [7:0]      rx_signaling_array [ARR_DEPTH];

  // apb decode
  logic            acc_done;
  logic            wr_done;
  logic            rd_done;
  logic [11:0]     idx;
  logic            hit_arr;
  logic            mapped;
  logic [31:0]     next_prdata;

  // stream decode
  logic [2:0]      code;
  logic            nat_ok;
  logic            nat_ones;
  logic            cas_on;
  logic            ts16_ext;
  logic            code_used;
  logic            is_ts0_nfas;
  logic            is_ts16;
  logic            de_frac;
  logic            de_sig;
  logic            ts16_hold;
  logic            arr_wr;
  logic            chg_hit;
  logic [7:0]      chg_set;
  logic            chg_clr;
  logic            dl_event;

  // access completes on the edge where pready is seen high
  assign acc_done  = psel & penable & pready;
  assign wr_done   = acc_done & pwrite;
  assign rd_done   = acc_done & ~pwrite;
  assign idx       = paddr[13:2];
  assign hit_arr   = (idx >= IDX_ARR_BASE) && (idx <= IDX_ARR_LAST);
  assign mapped    = hit_arr || (idx == IDX_SEL) || (idx == IDX_CHG) ||
                     (idx == IDX_ROUTE) || (idx == IDX_STAT) || (idx == IDX_MASK);

  // select code classes
  assign code      = rx_sig_link_select_reg.code;
  assign nat_ok    = (code == SEL_DL_PLAIN) || (code == SEL_DL_CAS) ||
                     (code == SEL_DL_SIG);
  assign nat_ones  = (code == SEL_ONES) || (code == SEL_ONES_CAS);
  assign cas_on    = (code == SEL_DL_CAS) || (code == SEL_ONES_CAS);
  assign ts16_ext  = cas_on || (code == SEL_ONES);
  assign code_used = nat_ok || nat_ones;

  // slot classes
  assign is_ts0_nfas = rx_slot.valid & (rx_slot.num == TS_FRAME) & ~rx_slot.fas;
  assign is_ts16     = rx_slot.valid & (rx_slot.num == TS_SIG);

  // d/e channel leaves serial under codes 000..100 unless routed there
  assign de_frac   = rx_slot.valid & rx_slot.de & code_used & ~route.de_to_serial &
                     (code != SEL_DL_SIG);
  assign de_sig    = rx_slot.valid & rx_slot.de & ~route.de_to_serial &
                     (code == SEL_DL_SIG);

  // timeslot 16 withheld from serial when extracted elsewhere
  assign ts16_hold = is_ts16 & ts16_ext & ~route.ts16_serial;

  // array write: cas modes always keep the signaling store, code 010 on request
  assign arr_wr    = is_ts16 & (cas_on | ((code == SEL_ONES) & route.ts16_array));

  // cas nibble for timeslots 1..7 differs from the stored copy
  assign chg_hit   = is_ts16 & cas_on & rx_cas_locked & (rx_slot.mf != MF_ALIGN) &
                     (rx_slot.mf <= MF_LAST_CHG) &
                     (rx_slot.data[7:4] !=
                      rx_signaling_array[{1'b0, rx_slot.mf}][3:0]);

  assign chg_clr   = rd_done & (idx == IDX_CHG);
  assign dl_event  = is_ts0_nfas & ((nat_ok & (|rx_sig_link_select_reg.nat_en)) | nat_ones);

  // per-bit set terms, bit 7 is timeslot 0 and stays inert
  genvar gi;
  generate
    for (gi = 0; gi < CHG_SLOTS; gi = gi + 1) begin : g_chg
      if (gi == CHG_SLOTS - 1) begin : g_ts0
        assign chg_set[gi] = 1'b0;
      end else begin : g_tsn
        assign chg_set[gi] = chg_hit &
                             (rx_slot.mf == 4'(CHG_SLOTS - 1 - gi));
      end
    end
  endgenerate

  // read data mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_arr) begin
      next_prdata[7:0] = rx_signaling_array[paddr[6:2]];
    end else begin
      case (idx)
        IDX_SEL:   next_prdata[7:0] = rx_sig_link_select_reg;
        IDX_CHG:   next_prdata[7:0] = rx_sig_change_reg0;
        IDX_ROUTE: next_prdata[7:0] = route;
        IDX_STAT:  next_prdata[STAT_W-1:0] = status;
        IDX_MASK:  next_prdata[STAT_W-1:0] = mask;
        default:   next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // apb handshake: one wait state, answer registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  // select register, code resets to 000
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sig_link_select_reg <= SEL_RESET;
    end else if (wr_done && idx == IDX_SEL) begin
      rx_sig_link_select_reg <= pwdata[7:0];
    end
  end

  // destination register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route <= ROUTE_RESET;
    end else if (wr_done && idx == IDX_ROUTE) begin
      route <= pwdata[7:0];
    end
  end

  // change flags: clear only what the read reported, a later set survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sig_change_reg0 <= CHG_RESET;
    end else begin
      rx_sig_change_reg0 <= (rx_sig_change_reg0 & ~(prdata[7:0] & {8{chg_clr}})) |
                            chg_set;
    end
  end

  // interrupt status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= STAT_RESET;
    end else begin
      status[STAT_CHG] <= (status[STAT_CHG] &
                           ~(wr_done && idx == IDX_STAT && pwdata[STAT_CHG])) | (|chg_set);
      status[STAT_DL]  <= (status[STAT_DL] &
                           ~(wr_done && idx == IDX_STAT && pwdata[STAT_DL])) | dl_event;
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= MASK_RESET;
    end else if (wr_done && idx == IDX_MASK) begin
      mask <= pwdata[STAT_W-1:0];
    end
  end

  // interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // signaling array: cas splits the byte into two channel nibbles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ARR_DEPTH; i++) begin
        rx_signaling_array[i] <= 8'h00;
      end
    end else if (arr_wr) begin
      if (cas_on) begin
        if (rx_slot.mf != MF_ALIGN) begin
          rx_signaling_array[{1'b0, rx_slot.mf}] <= {4'h0, rx_slot.data[7:4]};
          rx_signaling_array[{1'b1, rx_slot.mf}] <= {4'h0, rx_slot.data[3:0]};
        end
      end else begin
        rx_signaling_array[{1'b0, rx_slot.mf}] <= rx_slot.data;
      end
    end
  end

  // serial output carries the payload minus what is extracted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_serial_out <= '0;
    end else begin
      rx_serial_out.valid <= rx_slot.valid & ~de_frac & ~de_sig & ~ts16_hold;
      rx_serial_out.data  <= rx_slot.data;
    end
  end

  // fractional output takes the d/e channel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fractional_out <= '0;
    end else begin
      rx_fractional_out.valid <= de_frac;
      rx_fractional_out.data  <= rx_slot.data;
    end
  end

  // overhead output, timeslot 16 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_overhead_out <= '0;
    end else begin
      rx_overhead_out.valid <= is_ts16 & ts16_ext & route.ts16_overhead;
      rx_overhead_out.data  <= rx_slot.data;
    end
  end

  // signaling output: every slot under cas, ts16 only for 010
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_signaling_out <= '0;
    end else if (de_sig) begin
      rx_signaling_out.valid <= 1'b1;
      rx_signaling_out.data  <= rx_slot.data;
    end else if (cas_on & route.ts16_signaling & rx_slot.valid) begin
      rx_signaling_out.valid <= 1'b1;
      rx_signaling_out.data  <= rx_signaling_array[rx_slot.num];
    end else if ((code == SEL_ONES) & route.ts16_signaling & is_ts16) begin
      rx_signaling_out.valid <= 1'b1;
      rx_signaling_out.data  <= rx_slot.data;
    end else begin
      rx_signaling_out.valid <= 1'b0;
      rx_signaling_out.data  <= rx_signaling_out.data;
    end
  end

  // national bits of non-fas timeslot 0 as data link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_dl_bits  <= 5'h00;
      rx_dl_valid <= 5'h00;
    end else if (is_ts0_nfas & nat_ok) begin
      // bit 4 nat8..bit 0 nat4 follow data bits 7..3
      rx_dl_bits[4]  <= rx_slot.data[7] & rx_sig_link_select_reg.nat_en[4];
      rx_dl_bits[3]  <= rx_slot.data[6] & rx_sig_link_select_reg.nat_en[3];
      rx_dl_bits[2]  <= rx_slot.data[5] & rx_sig_link_select_reg.nat_en[2];
      rx_dl_bits[1]  <= rx_slot.data[4] & rx_sig_link_select_reg.nat_en[1];
      rx_dl_bits[0]  <= rx_slot.data[3] & rx_sig_link_select_reg.nat_en[0];
      rx_dl_valid    <= rx_sig_link_select_reg.nat_en;
    end else if (is_ts0_nfas & nat_ones) begin
      rx_dl_bits  <= NAT_ONES;
      rx_dl_valid <= NAT_ONES;
    end else begin
      rx_dl_valid <= 5'h00;
    end
  end
endmodule
`default_nettype wire
